/* File: src/cbtg_bank.sv */
// cathode bias override and per-channel tia gain register bank
`timescale 1ns/1ps
`default_nettype none
module cbtg_bank (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic global_cathode_sel,
  input wire logic [1:0] op_state,
  input wire logic first_slot_gain_en,
  input wire logic second_slot_gain_en,
  input wire logic [1:0] first_slot_tia_gain,
  input wire logic [1:0] second_slot_tia_gain,
  output logic [2:0] cathode_src,
  output logic cathode_override_on,
  output logic [1:0] first_slot_ch4_gain,
  output logic [1:0] second_slot_ch4_gain,
  output logic [1:0] second_slot_ch3_gain,
  output logic [1:0] second_slot_ch2_gain
);

  // ==========================================================================
  // reset release
  logic rst_meta_reg;
  logic rst_sync_reg;

  // release is synchronised so all flops leave reset on the same edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ==========================================================================
  // register storage
  logic [15:0] override_reg;
  logic [15:0] gain_reg;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  // write strobes decoded once, each register sees one compare
  logic wr_override;
  logic wr_gain;

  assign wr_override = reg_wr && hit(reg_addr, cbtg_pkg::cbtg_addr_override);
  assign wr_gain = reg_wr && hit(reg_addr, cbtg_pkg::cbtg_addr_gain);

  // all bits are stored as written, reserved ones included, so reads echo writes
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      override_reg <= cbtg_pkg::cbtg_override_rst;
    end else if (wr_override) begin
      override_reg <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      gain_reg <= cbtg_pkg::cbtg_gain_rst;
    end else if (wr_gain) begin
      gain_reg <= reg_wdata;
    end
  end

  // ==========================================================================
  // register read, one cycle latency, unmapped reads give zero
  logic [15:0] rdata_next;

  always_comb begin
    rdata_next = cbtg_pkg::cbtg_read_zero;
    if (hit(reg_addr, cbtg_pkg::cbtg_addr_override)) begin
      rdata_next = override_reg;
    end else if (hit(reg_addr, cbtg_pkg::cbtg_addr_gain)) begin
      rdata_next = gain_reg;
    end
  end

  // valid is reg_rd delayed by one cycle, independent of the address
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  // data holds between reads so the port decoder may pick it up late
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      reg_rdata <= cbtg_pkg::cbtg_read_zero;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  // ==========================================================================
  // cathode selection
  logic [2:0] cathode_next;
  cbtg_pkg::cbtg_state_type state_now;

  assign state_now = cbtg_pkg::cbtg_state_type'(op_state);

  cbtg_cathode_sel u_cathode_sel (
    .override_on(override_reg[cbtg_pkg::cbtg_override_on_bit]),
    .global_cathode_sel(global_cathode_sel),
    .sleep_cathode_code(override_reg[cbtg_pkg::cbtg_sleep_cat_msb:cbtg_pkg::cbtg_sleep_cat_lsb]),
    .second_slot_cathode_code(
      override_reg[cbtg_pkg::cbtg_second_cat_msb:cbtg_pkg::cbtg_second_cat_lsb]),
    .first_slot_cathode_code(
      override_reg[cbtg_pkg::cbtg_first_cat_msb:cbtg_pkg::cbtg_first_cat_lsb]),
    .op_state(state_now),
    .cathode_src(cathode_next)
  );

  // outputs registered so the analog switches see no decode glitches
  // limitation: op_state is trusted as same-clock logic, no synchroniser
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      cathode_src <= cbtg_pkg::cbtg_cat_anode;
    end else begin
      cathode_src <= cathode_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      cathode_override_on <= 1'b0;
    end else begin
      cathode_override_on <= override_reg[cbtg_pkg::cbtg_override_on_bit];
    end
  end

  // ==========================================================================
  // per-channel gain, falls back to the slot gain when not enabled
  logic [1:0] b_ch4_gain_next;
  logic [1:0] b_ch3_gain_next;
  logic [1:0] b_ch2_gain_next;
  logic [1:0] a_ch4_gain_next;

  function automatic logic [1:0] gain_pick(input logic en, input logic [1:0] chan,
                                           input logic [1:0] slot);
    gain_pick = en ? chan : slot;
  endfunction

  // one enable per slot gates all of that slot's channels together
  always_comb begin
    b_ch4_gain_next = gain_pick(second_slot_gain_en,
      gain_reg[cbtg_pkg::cbtg_b_ch4_msb:cbtg_pkg::cbtg_b_ch4_lsb], second_slot_tia_gain);
    b_ch3_gain_next = gain_pick(second_slot_gain_en,
      gain_reg[cbtg_pkg::cbtg_b_ch3_msb:cbtg_pkg::cbtg_b_ch3_lsb], second_slot_tia_gain);
    b_ch2_gain_next = gain_pick(second_slot_gain_en,
      gain_reg[cbtg_pkg::cbtg_b_ch2_msb:cbtg_pkg::cbtg_b_ch2_lsb], second_slot_tia_gain);
    a_ch4_gain_next = gain_pick(first_slot_gain_en,
      gain_reg[cbtg_pkg::cbtg_a_ch4_msb:cbtg_pkg::cbtg_a_ch4_lsb], first_slot_tia_gain);
  end

  // gains lag the enables by one cycle, traded for glitch-free switch drive
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      second_slot_ch4_gain <= cbtg_pkg::cbtg_code_0;
    end else begin
      second_slot_ch4_gain <= b_ch4_gain_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      second_slot_ch3_gain <= cbtg_pkg::cbtg_code_0;
    end else begin
      second_slot_ch3_gain <= b_ch3_gain_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      second_slot_ch2_gain <= cbtg_pkg::cbtg_code_0;
    end else begin
      second_slot_ch2_gain <= b_ch2_gain_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      first_slot_ch4_gain <= cbtg_pkg::cbtg_code_0;
    end else begin
      first_slot_ch4_gain <= a_ch4_gain_next;
    end
  end

endmodule
`default_nettype wire

/* File: src/cbtg_pkg.sv */
// constants and types for the cathode bias and tia gain configuration bank
package cbtg_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] cbtg_addr_override = 8'h54;
  localparam logic [7:0] cbtg_addr_gain = 8'h55;
  localparam logic [15:0] cbtg_override_rst = 16'h0020;
  localparam logic [15:0] cbtg_gain_rst = 16'h0000;
  localparam logic [15:0] cbtg_read_zero = 16'h0000;

  // ==========================================================================
  // field positions in the override register
  localparam int cbtg_sleep_cat_msb = 13;
  localparam int cbtg_sleep_cat_lsb = 12;
  localparam int cbtg_second_cat_msb = 11;
  localparam int cbtg_second_cat_lsb = 10;
  localparam int cbtg_first_cat_msb = 9;
  localparam int cbtg_first_cat_lsb = 8;
  localparam int cbtg_override_on_bit = 7;

  // ==========================================================================
  // field positions in the gain register
  localparam int cbtg_b_ch4_msb = 11;
  localparam int cbtg_b_ch4_lsb = 10;
  localparam int cbtg_b_ch3_msb = 9;
  localparam int cbtg_b_ch3_lsb = 8;
  localparam int cbtg_b_ch2_msb = 7;
  localparam int cbtg_b_ch2_lsb = 6;
  localparam int cbtg_a_ch4_msb = 5;
  localparam int cbtg_a_ch4_lsb = 4;

  // ==========================================================================
  // two-bit cathode codes of the override fields
  localparam logic [1:0] cbtg_code_0 = 2'h0;
  localparam logic [1:0] cbtg_code_1 = 2'h1;
  localparam logic [1:0] cbtg_code_2 = 2'h2;
  localparam logic [1:0] cbtg_code_3 = 2'h3;

  // operating state reported by the sequencer
  typedef enum logic [1:0] {
    cbtg_st_sleep = 2'b00,
    cbtg_st_idle = 2'b01,
    cbtg_st_slot_a = 2'b10,
    cbtg_st_slot_b = 2'b11
  } cbtg_state_type;

  // cathode source driven to the analog bias switch
  typedef enum logic [2:0] {
    cbtg_cat_vdd = 3'b000,
    cbtg_cat_anode = 3'b001,
    cbtg_cat_rev_bias = 3'b010,
    cbtg_cat_zero = 3'b011,
    cbtg_cat_float = 3'b100,
    cbtg_cat_vref = 3'b101
  } cbtg_cathode_type;

endpackage

/* File: src/cbtg_cathode_sel.sv */
// cathode source selection from override fields and operating state
`timescale 1ns/1ps
`default_nettype none
module cbtg_cathode_sel (
  input wire logic override_on,
  input wire logic global_cathode_sel,
  input wire logic [1:0] sleep_cathode_code,
  input wire logic [1:0] second_slot_cathode_code,
  input wire logic [1:0] first_slot_cathode_code,
  input wire cbtg_pkg::cbtg_state_type op_state,
  output logic [2:0] cathode_src
);

  // ==========================================================================
  // slot code decode, shared by both slots
  function automatic logic [2:0] slot_decode(input logic [1:0] code);
    unique case (code)
      cbtg_pkg::cbtg_code_0: slot_decode = cbtg_pkg::cbtg_cat_vdd;
      cbtg_pkg::cbtg_code_1: slot_decode = cbtg_pkg::cbtg_cat_anode;
      cbtg_pkg::cbtg_code_2: slot_decode = cbtg_pkg::cbtg_cat_rev_bias;
      cbtg_pkg::cbtg_code_3: slot_decode = cbtg_pkg::cbtg_cat_zero;
    endcase
  endfunction

  // ==========================================================================
  // selection
  always_comb begin
    cathode_src = cbtg_pkg::cbtg_cat_vdd;
    if (!override_on) begin
      cathode_src = global_cathode_sel ? cbtg_pkg::cbtg_cat_vdd : cbtg_pkg::cbtg_cat_anode;
    end else begin
      unique case (op_state)
        cbtg_pkg::cbtg_st_sleep, cbtg_pkg::cbtg_st_idle: begin
          unique case (sleep_cathode_code)
            cbtg_pkg::cbtg_code_0: cathode_src = cbtg_pkg::cbtg_cat_vdd;
            cbtg_pkg::cbtg_code_1: begin
              // vref only while idle, supply once truly asleep
              cathode_src = (op_state == cbtg_pkg::cbtg_st_idle) ?
                            cbtg_pkg::cbtg_cat_vref : cbtg_pkg::cbtg_cat_vdd;
            end
            cbtg_pkg::cbtg_code_2: cathode_src = cbtg_pkg::cbtg_cat_float;
            cbtg_pkg::cbtg_code_3: cathode_src = cbtg_pkg::cbtg_cat_zero;
          endcase
        end
        cbtg_pkg::cbtg_st_slot_a: cathode_src = slot_decode(first_slot_cathode_code);
        cbtg_pkg::cbtg_st_slot_b: cathode_src = slot_decode(second_slot_cathode_code);
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: test/cbtg_bank_checker.sv */
// assertion checker for the cathode bias and gain bank
`timescale 1ns/1ps
`default_nettype none
module cbtg_bank_checker (
  input wire logic mclk, rst_n, reg_wr, reg_rd, reg_rvalid, cathode_override_on,
  input wire logic global_cathode_sel, first_slot_gain_en, second_slot_gain_en,
  input wire logic [1:0] op_state, first_slot_tia_gain, second_slot_tia_gain,
  input wire logic [1:0] first_slot_ch4_gain, second_slot_ch4_gain,
  input wire logic [1:0] second_slot_ch3_gain, second_slot_ch2_gain,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata, reg_rdata,
  input wire logic [2:0] cathode_src
);
  // ==========================================================================
  // shadow registers; outputs judged after four quiet cycles
  logic [15:0] ov_reg, gn_reg;
  logic [8:0] in_reg;
  logic [2:0] quiet_reg;
  wire logic [8:0] in_now = {global_cathode_sel, op_state, first_slot_gain_en,
    second_slot_gain_en, first_slot_tia_gain, second_slot_tia_gain};
  wire logic ok = quiet_reg == 3'h4;
  wire logic ovr = ov_reg[7];
  wire logic [1:0] sc = ov_reg[13:12];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ov_reg <= 16'h0020;
      gn_reg <= 16'h0000;
      in_reg <= 9'h000;
      quiet_reg <= 3'h0;
    end else begin
      if (reg_wr && reg_addr == 8'h54) ov_reg <= reg_wdata;
      if (reg_wr && reg_addr == 8'h55) gn_reg <= reg_wdata;
      in_reg <= in_now;
      // restart on any change: outputs lag, and reset lags two edges
      quiet_reg <= (reg_wr || in_now != in_reg) ? 3'h0 : quiet_reg + {2'h0, !ok};
    end
  end
  // ==========================================================================
  // assertions
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence rd_ov_s;
    reg_rd && !reg_wr && reg_addr == 8'h54;
  endsequence
  ovr_copy_a: assert property (ok |-> cathode_override_on == ovr)
    else $error("override flag wrong");
  global_cat_a: assert property (ok && !ovr |->
    cathode_src == {2'h0, !global_cathode_sel}) else $error("global cathode wrong");
  sleep_cat_a: assert property (ok && ovr && (op_state == 2'h0 ||
    sc == 2'h1 && op_state == 2'h1) |-> cathode_src ==
    (sc == 2'h2 ? 3'h4 : sc == 2'h3 ? 3'h3 : op_state[0] ? 3'h5 : 3'h0))
    else $error("sleep cathode wrong");
  slot_b_cat_a: assert property (ok && ovr && op_state == 2'h3 |->
    cathode_src == {1'b0, ov_reg[11:10]}) else $error("slot b cathode wrong");
  slot_a_cat_a: assert property (ok && ovr && op_state == 2'h2 |->
    cathode_src == {1'b0, ov_reg[9:8]}) else $error("slot a cathode wrong");
  b_ch4_gain_a: assert property (ok |-> second_slot_ch4_gain ==
    (second_slot_gain_en ? gn_reg[11:10] : second_slot_tia_gain)) else $error("b4 gain");
  b_ch3_gain_a: assert property (ok |-> second_slot_ch3_gain ==
    (second_slot_gain_en ? gn_reg[9:8] : second_slot_tia_gain)) else $error("b3 gain");
  b_ch2_gain_a: assert property (ok |-> second_slot_ch2_gain ==
    (second_slot_gain_en ? gn_reg[7:6] : second_slot_tia_gain)) else $error("b2 gain");
  a_ch4_gain_a: assert property (ok |-> first_slot_ch4_gain ==
    (first_slot_gain_en ? gn_reg[5:4] : first_slot_tia_gain)) else $error("a4 gain");
  read_back_a: assert property (rd_ov_s |=> reg_rvalid && reg_rdata == $past(ov_reg))
    else $error("read data wrong");
endmodule
`default_nettype wire

/* File: test/cbtg_bank_tb.sv */
// self-checking bench for the cathode bias and gain bank
`timescale 1ns/1ps
`default_nettype none
module cbtg_bank_tb;
  // ==========================================================================
  // rows: registers, inputs {sel, state, en a, en b, tia a, tia b}, outputs
  typedef struct packed {
    logic [15:0] ov;
    logic [15:0] gn;
    logic [8:0] stim;
    logic [2:0] cat;
    logic [7:0] gain;
  } cbtg_row_type;
  cbtg_row_type rows [15] = '{
    '{16'h0020, 16'h0ff0, 9'h0c6, 3'h1, 8'ha9}, '{16'h0020, 16'h0e40, 9'h1a1, 3'h0, 8'h54},
    '{16'h0080, 16'h0e40, 9'h01c, 3'h0, 8'he7}, '{16'h1080, 16'h0e40, 9'h01c, 3'h0, 8'he7},
    '{16'h1080, 16'h0e40, 9'h05c, 3'h5, 8'he7}, '{16'h2080, 16'h0e40, 9'h01c, 3'h4, 8'he7},
    '{16'h3080, 16'h0e40, 9'h01c, 3'h3, 8'he7}, '{16'h0380, 16'h0e40, 9'h0dc, 3'h0, 8'he7},
    '{16'h0680, 16'h0e40, 9'h0dc, 3'h1, 8'he7}, '{16'h0980, 16'h0e40, 9'h0dc, 3'h2, 8'he7},
    '{16'h0c80, 16'h0e40, 9'h0dc, 3'h3, 8'he7}, '{16'h0380, 16'h0e40, 9'h09c, 3'h3, 8'he7},
    '{16'h0680, 16'h0e40, 9'h09c, 3'h2, 8'he7}, '{16'h0980, 16'h0e40, 9'h09c, 3'h1, 8'he7},
    '{16'h0c80, 16'h0e40, 9'h09c, 3'h0, 8'he7}};
  logic mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid, ovr_on;
  logic [7:0] reg_addr = 8'h00, gains;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [8:0] stim = 9'h000;
  logic [2:0] cat;
  int err_count = 0, compares = 0;
  always #2 mclk = ~mclk;
  cbtg_bank uut (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .global_cathode_sel(stim[8]), .op_state(stim[7:6]),
    .first_slot_gain_en(stim[5]), .second_slot_gain_en(stim[4]),
    .first_slot_tia_gain(stim[3:2]), .second_slot_tia_gain(stim[1:0]),
    .cathode_src(cat), .cathode_override_on(ovr_on), .second_slot_ch4_gain(gains[7:6]),
    .second_slot_ch3_gain(gains[5:4]), .second_slot_ch2_gain(gains[3:2]),
    .first_slot_ch4_gain(gains[1:0]));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // idle edge after each access keeps strobes from being driven twice at once
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge mclk);
    #1 reg_wr = 1'b0;
    @(posedge mclk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    int n = 0;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge mclk);
    #1 reg_rd = 1'b0;
    while (reg_rvalid !== 1'b1) begin
      if (n == 4) begin
        err_count++;
        break;
      end
      n++;
      @(posedge mclk);
      #1;
    end
    chk(reg_rdata, exp);
    @(posedge mclk);
    #1;
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    foreach (rows[i]) begin
      wr(8'h54, rows[i].ov);
      wr(8'h55, rows[i].gn);
      stim = rows[i].stim;
      repeat (2) @(posedge mclk);
      #1 chk(cat, rows[i].cat);
      chk(ovr_on, rows[i].ov[7]);
      chk(gains, rows[i].gain);
      rd(8'h54, rows[i].ov);
      rd(8'h55, rows[i].gn);
    end
    // ==========================================================================
    // unmapped place, reserved bits, mid-run reset
    wr(8'h56, 16'hffff);
    rd(8'h56, 16'h0000);
    rd(8'h54, 16'h0c80);
    wr(8'h55, 16'hf5a5);
    rd(8'h55, 16'hf5a5);
    rst_n = 1'b0;
    #1 chk(cat, 3'h1);
    @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge mclk);
    #1 rd(8'h54, 16'h0020);
    rd(8'h55, 16'h0000);
    chk(cat, 3'h1);
    chk(gains, 8'h03);
    results;
  end
endmodule
bind cbtg_bank cbtg_bank_checker chk_i (.*);
`default_nettype wire
